// file: pcto_init_model.sv
/* pci initiator side: free-running 160 ns pci clock and status lines.
   assumes the bench calls its tasks; lines change on pci clock edges only. */
`timescale 1ns/1ps
module pcto_init_model
(
  output logic pci_clk, // pci clock
  output logic init_busy, // waiting on target
  output logic init_trdy, // target ready
  output logic init_retry, // retry seen
  output logic init_start // new transaction
);
  initial
  begin
    {init_busy, init_trdy, init_retry, init_start} = 4'h0;
    pci_clk = 1'h0;
    forever #80 pci_clk = ~pci_clk;
  end
  task automatic start;
    @(posedge pci_clk);
    init_start <= 1'h1;
    @(posedge pci_clk);
    init_start <= 1'h0;
  endtask
  // each retry is a full pci clock high so the core side cannot miss it
  task automatic retries(input int n);
    start;
    repeat (n)
    begin
      @(posedge pci_clk);
      init_retry <= 1'h1;
      @(posedge pci_clk);
      init_retry <= 1'h0;
    end
    repeat (3) @(posedge pci_clk);
  endtask
  task automatic trdy_wait(input int n);
    start;
    init_busy <= 1'h1;
    repeat (n) @(posedge pci_clk);
    init_trdy <= 1'h1;
    init_busy <= 1'h0;
    @(posedge pci_clk);
    init_trdy <= 1'h0;
    repeat (3) @(posedge pci_clk);
  endtask
endmodule

// file: pcto_limit_cnt.v
/*
  saturating event counter compared against a programmable limit.
  a limit of zero disables detection; over_o pulses once when the count passes the limit.
  assumes inc_i is a one-cycle pulse on the core clock; clr_i may also be a held level.
*/
`timescale 1ns/1ps
module pcto_limit_cnt
#(
  parameter W = 8
)
(
  input wire core_clk, // core clock
  input wire rst_n, // synchronous reset, active low
  input wire clr_i, // restart counting
  input wire inc_i, // one counted event
  input wire [W-1:0] limit_i, // limit, zero disables
  output reg over_o // pulse when count exceeds limit
);

reg [W:0] cnt_r;
reg [W:0] cnt_nxt;
reg fired_r;

always @*
begin
  cnt_nxt = cnt_r;
  if (clr_i)
    cnt_nxt = {(W+1){1'b0}};
  else if (inc_i && !cnt_r[W])
    cnt_nxt = cnt_r + {{W{1'b0}}, 1'b1};
end

always @(posedge core_clk)
begin
  if (!rst_n)
  begin
    cnt_r <= {(W+1){1'b0}};
    fired_r <= 1'b0;
    over_o <= 1'b0;
  end
  else
  begin
    cnt_r <= cnt_nxt;
    // one report per transaction; the count saturates instead of wrapping
    over_o <= 1'b0;
    if (clr_i)
      fired_r <= 1'b0;
    else if (!fired_r && (limit_i != {W{1'b0}}) && (cnt_nxt > {1'b0, limit_i}))
    begin
      over_o <= 1'b1;
      fired_r <= 1'b1;
    end
  end
end

endmodule

// file: pcto_map.vh
/*
  register map of the pci configuration header mirror and initiator timeout block:
  byte offsets, field positions, reset values and timing figures.
  assumes inclusion by bare name from the design files of this block.
*/
`ifndef PCTO_MAP_VH
`define PCTO_MAP_VH

`define PCTO_OFF_IO_BASE 16'hd024
`define PCTO_OFF_SUBSYS 16'hd02c
`define PCTO_OFF_CAP_PTR 16'hd034
`define PCTO_OFF_CFG2 16'hd03c
`define PCTO_OFF_TO_LIMITS 16'hd040
`define PCTO_OFF_TO_STATUS 16'hd080
`define PCTO_OFF_TO_MASK 16'hd084

`define PCTO_IO_BASE_HI 31
`define PCTO_IO_BASE_LO 8
`define PCTO_IO_WINDOW_BITS 8
`define PCTO_CAP_OFFSET 8'hdc
`define PCTO_MAXLAT_RST 8'h0a
`define PCTO_MINGNT_RST 8'h02
`define PCTO_INTPIN_RST 8'h01
`define PCTO_INTLINE_RST 8'h00
`define PCTO_RETRY_RST 8'h80
`define PCTO_TRDY_RST 8'h80
`define PCTO_SUBSYS_RST 16'h0000

`define PCTO_ST_TRDY_BIT 1
`define PCTO_ST_RETRY_BIT 0

`define PCTO_LAT_UNIT_NS 250

`endif

// file: pcto_regs.v
/*
  configuration header mirror and initiator timeout registers on a classic
  wishbone slave, with sticky timeout flags, mask and one level interrupt.
  assumes the pci clock and initiator status lines come from another domain and
  are sampled here; eeprom load values arrive on the core clock with a strobe.
*/
// Register access over Wishbone is this design's own decision.
// Summary of operation
// R1: endpoint-only mode blocks all local register access
// R2: io base bits 31:8 writable, 256-byte window
// R3: io base bit 0 always reads one
// R4: subsystem ids read-only, eeprom loadable
// R5: capability pointer reads constant dc
// R6: max latency resets 0a, eeprom loadable
// R7: min grant resets 02, eeprom loadable
// R8: interrupt pin resets 01, eeprom loadable
// R9: interrupt line plain read/write, no effect
// R10: too many retries ends transaction with error
// R11: software normally sets retry limit zero
// R12: target-ready wait over limit flags timeout
// R13: software normally sets target-ready limit zero
// R14: sticky timeout flags, write one clears
// R15: per-flag enable gates interrupt output
// R16: reserved bits read zero, writes ignored
`timescale 1ns/1ps
`include "pcto_map.vh"
module pcto_regs
(
  input wire core_clk, // core clock, 50 MHz
  input wire rst_n, // synchronous reset, active low
  input wire [15:0] wb_adr_i, // wishbone byte address
  input wire [31:0] wb_dat_i, // wishbone write data
  output reg [31:0] wb_dat_o, // wishbone read data
  input wire [3:0] wb_sel_i, // wishbone byte lanes
  input wire wb_we_i, // wishbone write
  input wire wb_cyc_i, // wishbone cycle
  input wire wb_stb_i, // wishbone strobe
  output reg wb_ack_o, // wishbone acknowledge
  output reg wb_err_o, // wishbone error (unmapped or blocked)
  input wire endpoint_only_mode, // endpoint-only mode strap level
  input wire eeprom_load_stb, // one-cycle eeprom load strobe
  input wire [15:0] eeprom_subsys_ident, // loaded subsystem id
  input wire [15:0] eeprom_subsys_vendor_ident, // loaded subsystem vendor id
  input wire [7:0] eeprom_max_latency, // loaded max latency
  input wire [7:0] eeprom_min_grant, // loaded min grant
  input wire [7:0] eeprom_interrupt_pin, // loaded interrupt pin
  input wire pci_clk, // pci clock, sampled
  input wire init_busy, // initiator data phase waiting on target ready
  input wire init_trdy, // target ready seen
  input wire init_retry, // retry termination seen
  input wire init_start, // new initiator transaction
  input wire [31:0] pci_io_addr, // pci i/o address to decode
  output reg io_window_hit, // address inside the i/o window
  output reg retry_timeout_err, // pulse: end transaction with error
  output reg trdy_timeout_err, // pulse: target-ready wait exceeded
  output wire [7:0] max_latency_field, // to arbiter request logic
  output wire [7:0] min_grant_field, // to latency timer logic
  output wire [7:0] interrupt_pin_select, // to configuration space
  output wire irq // level interrupt
);

////////////////////////////////////////////////////////////////////////////////
// register state

reg [23:0] io_base_r;
reg [15:0] subsys_ident_r;
reg [15:0] subsys_vendor_ident_r;
reg [7:0] max_latency_r;
reg [7:0] min_grant_r;
reg [7:0] interrupt_pin_r;
reg [7:0] interrupt_line_byte_r;
reg [7:0] retry_limit_r;
reg [7:0] target_ready_wait_limit_r;
reg target_ready_timeout_flag_r;
reg retry_timeout_flag_r;
reg target_ready_timeout_irq_en_r;
reg retry_timeout_irq_en_r;

assign max_latency_field = max_latency_r;
assign min_grant_field = min_grant_r;
assign interrupt_pin_select = interrupt_pin_r;

////////////////////////////////////////////////////////////////////////////////
// synchronisers for signals from the pci domain

wire pci_clk_s;
wire busy_s;
wire trdy_s;
wire retry_s;
wire start_s;
reg pci_clk_d_r;

// all five lines share one latency, so their relative timing is kept
pcto_sync u_sync_clk
(
  .core_clk(core_clk),
  .rst_n(rst_n),
  .d_in(pci_clk),
  .q_out(pci_clk_s)
);

pcto_sync u_sync_busy
(
  .core_clk(core_clk),
  .rst_n(rst_n),
  .d_in(init_busy),
  .q_out(busy_s)
);

pcto_sync u_sync_trdy
(
  .core_clk(core_clk),
  .rst_n(rst_n),
  .d_in(init_trdy),
  .q_out(trdy_s)
);

pcto_sync u_sync_retry
(
  .core_clk(core_clk),
  .rst_n(rst_n),
  .d_in(init_retry),
  .q_out(retry_s)
);

pcto_sync u_sync_start
(
  .core_clk(core_clk),
  .rst_n(rst_n),
  .d_in(init_start),
  .q_out(start_s)
);

// edge detectors reset low, the idle level of each line, so reset gives no false edge
reg retry_d_r;
reg start_d_r;
wire pci_edge = pci_clk_s & ~pci_clk_d_r;
wire retry_pulse = retry_s & ~retry_d_r;
wire start_pulse = start_s & ~start_d_r;

always @(posedge core_clk)
begin
  if (!rst_n)
  begin
    pci_clk_d_r <= 1'b0;
    retry_d_r <= 1'b0;
    start_d_r <= 1'b0;
  end
  else
  begin
    pci_clk_d_r <= pci_clk_s;
    retry_d_r <= retry_s;
    start_d_r <= start_s;
  end
end

////////////////////////////////////////////////////////////////////////////////
// timeout counters

wire retry_over;
wire trdy_over;

// retries are counted across one transaction; a new start restarts them
pcto_limit_cnt #(.W(8)) u_retry_cnt
(
  .core_clk(core_clk),
  .rst_n(rst_n),
  .clr_i(start_pulse),
  .inc_i(retry_pulse),
  .limit_i(retry_limit_r),
  .over_o(retry_over) // see R10
);

// wait is measured in rising pci clock edges while no target ready has appeared
pcto_limit_cnt #(.W(8)) u_trdy_cnt
(
  .core_clk(core_clk),
  .rst_n(rst_n),
  .clr_i(start_pulse | trdy_s | ~busy_s),
  .inc_i(pci_edge & busy_s),
  .limit_i(target_ready_wait_limit_r),
  .over_o(trdy_over) // see R12
);

always @(posedge core_clk)
begin
  if (!rst_n)
  begin
    retry_timeout_err <= 1'b0;
    trdy_timeout_err <= 1'b0;
    io_window_hit <= 1'b0;
  end
  else
  begin
    retry_timeout_err <= retry_over; // see R10
    trdy_timeout_err <= trdy_over; // see R12
    // window size is fixed; only the upper bits are compared
    io_window_hit <= (pci_io_addr[`PCTO_IO_BASE_HI:`PCTO_IO_BASE_LO] == io_base_r); // see R2
  end
end

////////////////////////////////////////////////////////////////////////////////
// wishbone decode

wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
reg hit;
reg [31:0] rd_val;

always @*
begin
  hit = 1'b1;
  rd_val = 32'h00000000; // see R16
  case (wb_adr_i)
    `PCTO_OFF_IO_BASE: rd_val = {io_base_r, 7'h00, 1'b1}; // see R3
    `PCTO_OFF_SUBSYS: rd_val = {subsys_ident_r, subsys_vendor_ident_r};
    `PCTO_OFF_CAP_PTR: rd_val = {24'h000000, `PCTO_CAP_OFFSET}; // see R5
    `PCTO_OFF_CFG2: rd_val = {max_latency_r, min_grant_r, interrupt_pin_r,
      interrupt_line_byte_r};
    `PCTO_OFF_TO_LIMITS: rd_val = {16'h0000, retry_limit_r, target_ready_wait_limit_r};
    `PCTO_OFF_TO_STATUS: rd_val = {30'h00000000, target_ready_timeout_flag_r,
      retry_timeout_flag_r};
    `PCTO_OFF_TO_MASK: rd_val = {30'h00000000, target_ready_timeout_irq_en_r,
      retry_timeout_irq_en_r};
    default: hit = 1'b0;
  endcase
end

// endpoint-only mode answers every access with an error and changes nothing
wire blocked = endpoint_only_mode; // see R1
wire wr = req & wb_we_i & hit & ~blocked;
wire st_clr_trdy = wr && wb_adr_i == `PCTO_OFF_TO_STATUS && wb_sel_i[0]
  && wb_dat_i[`PCTO_ST_TRDY_BIT];
wire st_clr_retry = wr && wb_adr_i == `PCTO_OFF_TO_STATUS && wb_sel_i[0]
  && wb_dat_i[`PCTO_ST_RETRY_BIT];

always @(posedge core_clk)
begin
  if (!rst_n)
  begin
    wb_ack_o <= 1'b0;
    wb_err_o <= 1'b0;
    wb_dat_o <= 32'h00000000;
  end
  else
  begin
    wb_ack_o <= req & hit & ~blocked;
    wb_err_o <= req & (~hit | blocked); // see R1
    wb_dat_o <= (req & hit & ~blocked & ~wb_we_i) ? rd_val : 32'h00000000;
  end
end

////////////////////////////////////////////////////////////////////////////////
// register writes, eeprom loads and sticky flags

always @(posedge core_clk)
begin
  if (!rst_n)
  begin
    io_base_r <= 24'h000000;
    subsys_ident_r <= `PCTO_SUBSYS_RST;
    subsys_vendor_ident_r <= `PCTO_SUBSYS_RST;
    max_latency_r <= `PCTO_MAXLAT_RST; // see R6
    min_grant_r <= `PCTO_MINGNT_RST; // see R7
    interrupt_pin_r <= `PCTO_INTPIN_RST; // see R8
    interrupt_line_byte_r <= `PCTO_INTLINE_RST; // see R9
    retry_limit_r <= `PCTO_RETRY_RST;
    target_ready_wait_limit_r <= `PCTO_TRDY_RST;
    target_ready_timeout_flag_r <= 1'b0;
    retry_timeout_flag_r <= 1'b0;
    target_ready_timeout_irq_en_r <= 1'b0;
    retry_timeout_irq_en_r <= 1'b0;
  end
  else
  begin
    if (eeprom_load_stb)
    begin
      subsys_ident_r <= eeprom_subsys_ident; // see R4
      subsys_vendor_ident_r <= eeprom_subsys_vendor_ident; // see R4
      max_latency_r <= eeprom_max_latency; // see R6
      min_grant_r <= eeprom_min_grant; // see R7
      interrupt_pin_r <= eeprom_interrupt_pin; // see R8
    end
    if (wr && wb_adr_i == `PCTO_OFF_IO_BASE)
    begin
      if (wb_sel_i[1])
      begin
        io_base_r[7:0] <= wb_dat_i[15:8]; // see R2
      end
      if (wb_sel_i[2])
      begin
        io_base_r[15:8] <= wb_dat_i[23:16];
      end
      if (wb_sel_i[3])
      begin
        io_base_r[23:16] <= wb_dat_i[31:24];
      end
    end
    // interrupt line is storage only; nothing in the block reads it
    if (wr && wb_adr_i == `PCTO_OFF_CFG2 && wb_sel_i[0])
    begin
      interrupt_line_byte_r <= wb_dat_i[7:0]; // see R9
    end
    // a zero limit switches detection off; both reset to 80 and software normally sets both to zero
    if (wr && wb_adr_i == `PCTO_OFF_TO_LIMITS)
    begin
      if (wb_sel_i[0])
      begin
        target_ready_wait_limit_r <= wb_dat_i[7:0]; // see R12
      end
      if (wb_sel_i[1])
      begin
        retry_limit_r <= wb_dat_i[15:8]; // see R10
      end
    end
    if (wr && wb_adr_i == `PCTO_OFF_TO_MASK && wb_sel_i[0])
    begin
      target_ready_timeout_irq_en_r <= wb_dat_i[`PCTO_ST_TRDY_BIT]; // see R15
      retry_timeout_irq_en_r <= wb_dat_i[`PCTO_ST_RETRY_BIT]; // see R15
    end
    // a detection in the clearing cycle wins over the clear
    if (trdy_over)
    begin
      target_ready_timeout_flag_r <= 1'b1; // see R14
    end
    else if (st_clr_trdy)
    begin
      target_ready_timeout_flag_r <= 1'b0; // see R14
    end
    if (retry_over)
    begin
      retry_timeout_flag_r <= 1'b1; // see R14
    end
    else if (st_clr_retry)
    begin
      retry_timeout_flag_r <= 1'b0; // see R14
    end
  end
end

assign irq = (target_ready_timeout_flag_r & target_ready_timeout_irq_en_r) |
  (retry_timeout_flag_r & retry_timeout_irq_en_r); // see R15

endmodule

// file: pcto_regs_bench.sv
/* bench for pcto_regs: wishbone master tasks and one task per scenario.
   assumes pcto_init_model plays the pci initiator side. */
`timescale 1ns/1ps
module pcto_regs_bench;
  logic core_clk = '0, rst_n = '0, wb_we_i = '0, wb_cyc_i = '0, wb_stb_i = '0, er;
  logic endpoint_only_mode = '0, eeprom_load_stb = '0;
  logic pci_clk, init_busy, init_trdy, init_retry, init_start;
  logic [15:0] wb_adr_i = '0, eeprom_subsys_ident = '0, eeprom_subsys_vendor_ident = '0;
  logic [31:0] wb_dat_i = '0, pci_io_addr = '0, wb_dat_o, rd;
  logic [3:0] wb_sel_i = '0;
  logic [7:0] eeprom_max_latency = '0, eeprom_min_grant = '0, eeprom_interrupt_pin = '0;
  logic [7:0] max_latency_field, min_grant_field, interrupt_pin_select;
  logic wb_ack_o, wb_err_o, io_window_hit, retry_timeout_err, trdy_timeout_err, irq;
  logic [15:0] regs [7] = '{16'hd024, 16'hd02c, 16'hd034, 16'hd03c, 16'hd040, 16'hd080,
    16'hd084};
  int errors = 0, check_count = 0;
  logic [31:0] n_retry = '0, n_trdy = '0;
  logic [3:0] lanes = 4'hf;
  pcto_regs i_pcto_regs (.core_clk, .rst_n, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_sel_i,
    .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_err_o, .endpoint_only_mode,
    .eeprom_load_stb, .eeprom_subsys_ident, .eeprom_subsys_vendor_ident,
    .eeprom_max_latency, .eeprom_min_grant, .eeprom_interrupt_pin, .pci_clk,
    .init_busy, .init_trdy, .init_retry, .init_start, .pci_io_addr, .io_window_hit,
    .retry_timeout_err, .trdy_timeout_err, .max_latency_field, .min_grant_field,
    .interrupt_pin_select, .irq);
  pcto_init_model i_pcto_init_model (.pci_clk, .init_busy, .init_trdy, .init_retry,
    .init_start);
  initial forever #10 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    n_retry <= n_retry + retry_timeout_err;
    n_trdy <= n_trdy + trdy_timeout_err;
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // holds the request until ack or err is sampled; only the bench timeout stops a hang
  task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'h3, w, a, d, lanes};
    do
    begin
      @(posedge core_clk);
    end
    while (wb_ack_o !== 1'h1 && wb_err_o !== 1'h1);
    rd = wb_dat_o;
    er = wb_err_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask
  task automatic rdc(input string n, input logic [15:0] a, input logic [31:0] e);
    wb(1'h0, a, '0);
    chk(n, e, rd);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [31:0] e [7] = '{32'h1, '0, 32'hdc, 32'h0a020100, 32'h8080, '0, '0};
    for (int i = 0; i < 7; i++)
      rdc("reset value", regs[i], e[i]);
  endtask
  task automatic t_write;
    logic [31:0] e [5] = '{32'hffff1201, '0, 32'hdc, 32'h0a0201ff, 32'h12ff};
    for (int i = 0; i < 5; i++)
    begin
      wb(1'h1, regs[i], 32'hffff12ff);
      rdc("write back", regs[i], e[i]);
    end
    lanes = 4'h2;
    wb(1'h1, 16'hd040, 32'hffff3456);
    lanes = 4'hf;
    rdc("lane write", 16'hd040, 32'h34ff);
    wb(1'h0, 16'hd030, '0);
    chk("unmapped err", 1'h1, er);
    pci_io_addr <= 32'hffff12ff;
    repeat (2) @(posedge core_clk);
    chk("window hit", 1'h1, io_window_hit);
    pci_io_addr <= 32'hffff1300;
    repeat (2) @(posedge core_clk);
    chk("window miss", 1'h0, io_window_hit);
  endtask
  // every interrupt pin code, with ids of arbitrary value
  task automatic t_eeprom;
    logic [7:0] p;
    for (int i = 0; i < 5; i++)
    begin
      p = i[7:0];
      @(posedge core_clk);
      eeprom_load_stb <= 1'h1;
      eeprom_subsys_ident <= {8'h5a, 8'h30 | p};
      eeprom_subsys_vendor_ident <= {8'hc3, 8'ha0 | p};
      eeprom_max_latency <= 8'h30 | p;
      eeprom_min_grant <= 8'hc0 | p;
      eeprom_interrupt_pin <= p;
      @(posedge core_clk);
      eeprom_load_stb <= 1'h0;
      rdc("loaded cfg2", 16'hd03c, {8'h30 | p, 8'hc0 | p, p, 8'hff});
      chk("pin port", {8'h00, 8'h30 | p, 8'hc0 | p, p}, {max_latency_field, min_grant_field,
        interrupt_pin_select});
    end
    rdc("loaded ids", 16'hd02c, 32'h5a34c3a4);
  endtask
  task automatic t_retry;
    wb(1'h1, 16'hd040, 32'h0300);
    wb(1'h1, 16'hd084, 32'h1);
    i_pcto_init_model.retries(3);
    chk("retry errs", 0, n_retry);
    i_pcto_init_model.retries(4);
    chk("retry errs", 1, n_retry);
    rdc("status", 16'hd080, 32'h1);
    chk("irq", 1'h1, irq);
    wb(1'h1, 16'hd084, 32'h0);
    chk("irq masked", 1'h0, irq);
    wb(1'h1, 16'hd080, 32'h1);
    rdc("status", 16'hd080, 32'h0);
    wb(1'h1, 16'hd040, 32'h0);
    i_pcto_init_model.retries(5);
    chk("retry off", 1, n_retry);
  endtask
  task automatic t_trdy;
    wb(1'h1, 16'hd040, 32'h05);
    wb(1'h1, 16'hd084, 32'h2);
    i_pcto_init_model.trdy_wait(4);
    chk("wait errs", 0, n_trdy);
    i_pcto_init_model.trdy_wait(10);
    chk("wait errs", 1, n_trdy);
    rdc("status", 16'hd080, 32'h2);
    chk("irq", 1'h1, irq);
    wb(1'h1, 16'hd080, 32'h2);
    chk("irq cleared", 1'h0, irq);
    wb(1'h1, 16'hd040, 32'h0);
    i_pcto_init_model.trdy_wait(10);
    chk("wait off", 1, n_trdy);
  endtask
  task automatic t_block;
    @(posedge core_clk);
    endpoint_only_mode <= 1'h1;
    wb(1'h1, 16'hd040, 32'hffff);
    chk("blocked err", 1'h1, er);
    wb(1'h0, 16'hd024, '0);
    chk("blocked data", '0, rd);
    endpoint_only_mode <= 1'h0;
    rdc("unchanged", 16'hd040, '0);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (40000) @(posedge core_clk);
    errors++;
    end_of_test;
  end
  initial
  begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1'h1;
    t_reset;
    t_write;
    t_eeprom;
    t_retry;
    t_trdy;
    t_block;
    end_of_test;
  end
endmodule

// file: pcto_regs_monitor.sv
/* checker for the pcto_regs ports: bus answers, fixed fields, error pulses.
   bound to every pcto_regs instance; one clock domain only. */
`timescale 1ns/1ps
module pcto_regs_monitor
(
  input wire core_clk, // clock
  input wire rst_n, // reset
  input wire [15:0] wb_adr_i, // address
  input wire wb_we_i, // write
  input wire wb_cyc_i, // cycle
  input wire wb_stb_i, // strobe
  input wire [31:0] wb_dat_o, // read data
  input wire wb_ack_o, // ack
  input wire wb_err_o, // error
  input wire endpoint_only_mode, // block mode
  input wire retry_timeout_err, // retry pulse
  input wire trdy_timeout_err, // wait pulse
  input wire [7:0] max_latency_field, // max latency
  input wire [7:0] min_grant_field, // min grant
  input wire [7:0] interrupt_pin_select // int pin
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  endsequence
  sequence s_rd(logic [15:0] a);
    s_req ##0 (!wb_we_i && wb_adr_i == a && !endpoint_only_mode);
  endsequence
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held over one cycle");
  chk_req_answer: assert property (s_req |=> wb_ack_o ^ wb_err_o)
    else $error("request not answered next cycle");
  chk_block_err: assert property (s_req ##0 endpoint_only_mode |=> wb_err_o)
    else $error("blocked access not refused");
  chk_err_quiet: assert property (wb_err_o |-> wb_dat_o == 32'h0 && !wb_ack_o)
    else $error("refused access returned data");
  chk_cap_read: assert property (s_rd(16'hd034) |=> wb_ack_o && wb_dat_o == 32'hdc)
    else $error("capability offset wrong");
  chk_io_low: assert property (s_rd(16'hd024) |=> wb_dat_o[7:0] == 8'h01)
    else $error("io base low byte wrong");
  chk_limit_high: assert property (s_rd(16'hd040) |=> wb_dat_o[31:16] == 16'h0)
    else $error("limit upper half not zero");
  chk_reset_fields: assert property ($rose(rst_n) |-> {max_latency_field, min_grant_field,
    interrupt_pin_select} == 24'h0a0201) else $error("field reset values wrong");
  chk_retry_once: assert property (retry_timeout_err |=> !retry_timeout_err)
    else $error("retry error pulse too long");
  chk_trdy_once: assert property ($rose(trdy_timeout_err) |=> $fell(trdy_timeout_err))
    else $error("wait error pulse too long");
endmodule
////////////////////////////////////////////////////////////////
bind pcto_regs pcto_regs_monitor i_pcto_regs_monitor (.core_clk, .rst_n, .wb_adr_i,
  .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .endpoint_only_mode,
  .retry_timeout_err, .trdy_timeout_err, .max_latency_field, .min_grant_field,
  .interrupt_pin_select);

// file: pcto_sync.v
/*
  two flip-flop synchroniser for one level from outside the core clock domain.
  assumes a free-running core clock; first stage is read only by the second.
*/
`timescale 1ns/1ps
module pcto_sync
(
  input wire core_clk, // core clock
  input wire rst_n, // synchronous reset, active low
  input wire d_in, // asynchronous level
  output wire q_out // synchronised level
);

reg meta_r;
reg sync_r;

always @(posedge core_clk)
begin
  if (!rst_n)
  begin
    meta_r <= 1'b0;
    sync_r <= 1'b0;
  end
  else
  begin
    meta_r <= d_in;
    sync_r <= meta_r;
  end
end

assign q_out = sync_r;

endmodule
